// file: logic/lot_counter_set.sv
// One counter set: OK and total counts, settings shadow and latched messages
`timescale 1ns/1ps
module lot_counter_set #(
  parameter int WIDTH = lot_counter_pkg::COUNT_W
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic countEn, // Measurement done, counting allowed
  input wire logic resultOk, // Measurement result is OK
  input wire logic clearCounts, // Operator reset of this set
  input wire logic accept, // Apply pending settings
  input wire logic [WIDTH-1:0] okWarnLimitIn, // Pending OK message limit
  input wire logic [WIDTH-1:0] allWarnLimitIn, // Pending total message limit
  input wire logic [WIDTH-1:0] okStopLimitIn, // Pending OK stop limit
  input wire logic [WIDTH-1:0] allStopLimitIn, // Pending total stop limit
  input wire logic showOkIn, // Pending show-OK flag
  input wire logic showAllIn, // Pending show-total flag
  output logic [WIDTH-1:0] okCount, // OK part count
  output logic [WIDTH-1:0] allCount, // Total part count
  output logic showOk, // Applied show-OK flag
  output logic showAll, // Applied show-total flag
  output logic [lot_counter_pkg::MSG_W-1:0] msg // Latched messages
);
  logic [WIDTH-1:0] okWarnLimit_reg, allWarnLimit_reg, okStopLimit_reg, allStopLimit_reg;
  logic [WIDTH-1:0] okCount_next, allCount_next;
  logic [lot_counter_pkg::MSG_W-1:0] hit;

  // ****************************************
  // Settings
  // ****************************************
  // Applied on accept
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      okWarnLimit_reg <= WIDTH'(lot_counter_pkg::LIMIT_OFF);
      allWarnLimit_reg <= WIDTH'(lot_counter_pkg::LIMIT_OFF);
      okStopLimit_reg <= WIDTH'(lot_counter_pkg::LIMIT_OFF);
      allStopLimit_reg <= WIDTH'(lot_counter_pkg::LIMIT_OFF);
      showOk <= 1'b0;
      showAll <= 1'b0;
    end else if (accept) begin
      okWarnLimit_reg <= okWarnLimitIn;
      allWarnLimit_reg <= allWarnLimitIn;
      okStopLimit_reg <= okStopLimitIn;
      allStopLimit_reg <= allStopLimitIn;
      showOk <= showOkIn;
      showAll <= showAllIn;
    end
  end

  // ****************************************
  // Counting
  // ****************************************
  // Total always, OK only on good
  always_comb begin
    okCount_next = okCount;
    allCount_next = allCount;
    if (countEn) begin
      allCount_next = allCount + WIDTH'(lot_counter_pkg::COUNT_ONE);
      if (resultOk) begin
        okCount_next = okCount + WIDTH'(lot_counter_pkg::COUNT_ONE);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clearCounts) begin
      okCount <= WIDTH'(lot_counter_pkg::COUNT_RESET);
      allCount <= WIDTH'(lot_counter_pkg::COUNT_RESET);
    end else begin
      okCount <= okCount_next;
      allCount <= allCount_next;
    end
  end

  // ****************************************
  // Messages
  // ****************************************
  // Zero limit disables compare; hit on equality as count changes
  always_comb begin
    hit = '0;
    hit[lot_counter_pkg::MSG_OK_WARN] = (okWarnLimit_reg != WIDTH'(lot_counter_pkg::LIMIT_OFF))
      && (okCount_next == okWarnLimit_reg) && (okCount_next != okCount);
    hit[lot_counter_pkg::MSG_ALL_WARN] = (allWarnLimit_reg != WIDTH'(lot_counter_pkg::LIMIT_OFF))
      && (allCount_next == allWarnLimit_reg) && (allCount_next != allCount);
    hit[lot_counter_pkg::MSG_OK_STOP] = (okStopLimit_reg != WIDTH'(lot_counter_pkg::LIMIT_OFF))
      && (okCount_next == okStopLimit_reg) && (okCount_next != okCount);
    hit[lot_counter_pkg::MSG_ALL_STOP] = (allStopLimit_reg != WIDTH'(lot_counter_pkg::LIMIT_OFF))
      && (allCount_next == allStopLimit_reg) && (allCount_next != allCount);
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clearCounts) begin
      msg <= '0;
    end else begin
      msg <= msg | hit;
    end
  end
endmodule // lot_counter_set

// file: logic/lot_size_part_counters.sv
// Job and shift lot counters with warning and switch-off handling
// Notes on behaviour
// - Job set keeps an OK count and a count of all parts.
// - Shift set keeps its own independent OK and total counts.
// - A set reset clears its OK and total counts together.
// - Each set has show flags for OK and total counts.
// - OK count reaching its message limit latches a yellow warning.
// - Total count reaching its message limit latches a yellow warning.
// - A limit of zero disables its comparison.
// - Reaching a stop limit ends the process and latches a red message.
// - Job OK stop drops ready and reports an error.
// - After stop and set reset, measurements are accepted again.
// - Job total stop: warning only or halt; halt chosen here.
// - Shift OK or total stop shuts the process and issues a message.
// - Zero stop limit never stops nor reports.
// - New limits and show flags apply only on accept.
`timescale 1ns/1ps
module lot_size_part_counters #(
  parameter int WIDTH = lot_counter_pkg::COUNT_W
) (
  input wire logic clk, // System clock, 20 MHz
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic measDone, // One-cycle pulse per finished measurement
  input wire logic measOk, // Result of that measurement is OK
  input wire logic [1:0] clearSet, // Operator reset per set (0 job, 1 shift)
  input wire logic [1:0] acceptSet, // Apply settings per set
  input wire logic [2*WIDTH-1:0] ok_warn_limit, // Pending OK message limits
  input wire logic [2*WIDTH-1:0] all_parts_warn_limit, // Pending total message limits
  input wire logic [2*WIDTH-1:0] ok_stop_limit, // Pending OK stop limits
  input wire logic [2*WIDTH-1:0] all_parts_stop_limit, // Pending total stop limits
  input wire logic [1:0] showOkIn, // Pending show-OK flags
  input wire logic [1:0] showAllIn, // Pending show-total flags
  output logic [2*WIDTH-1:0] okCount, // OK counts per set
  output logic [2*WIDTH-1:0] allCount, // Total counts per set
  output logic [1:0] showOk, // Applied show-OK flags
  output logic [1:0] showAll, // Applied show-total flags
  output logic [1:0] yellowMsg, // Latched warning per set
  output logic [1:0] redMsg, // Latched stop message per set
  output logic errorOut, // Job OK stop error
  output logic ready // Process may run
);
  logic [2*lot_counter_pkg::MSG_W-1:0] msgs;
  logic [1:0] halt;
  lot_counter_pkg::run_state_t state_reg, state_next;

  // ****************************************
  // Counter sets
  // ****************************************
  // One independent set per job and shift
  for (genvar s = 0; s < lot_counter_pkg::NUM_SETS; s++) begin : g_set
    logic [lot_counter_pkg::MSG_W-1:0] m;
    lot_counter_set #(.WIDTH(WIDTH)) u_set (
      .clk(clk),
      .sys_rst(sys_rst),
      // Counting only while the process runs
      .countEn(measDone && state_reg == lot_counter_pkg::RUN),
      .resultOk(measOk),
      .clearCounts(clearSet[s]),
      .accept(acceptSet[s]),
      .okWarnLimitIn(ok_warn_limit[s*WIDTH +: WIDTH]),
      .allWarnLimitIn(all_parts_warn_limit[s*WIDTH +: WIDTH]),
      .okStopLimitIn(ok_stop_limit[s*WIDTH +: WIDTH]),
      .allStopLimitIn(all_parts_stop_limit[s*WIDTH +: WIDTH]),
      .showOkIn(showOkIn[s]),
      .showAllIn(showAllIn[s]),
      .okCount(okCount[s*WIDTH +: WIDTH]),
      .allCount(allCount[s*WIDTH +: WIDTH]),
      .showOk(showOk[s]),
      .showAll(showAll[s]),
      .msg(m)
    );
    assign msgs[s*lot_counter_pkg::MSG_W +: lot_counter_pkg::MSG_W] = m;
    assign yellowMsg[s] = m[lot_counter_pkg::MSG_OK_WARN] | m[lot_counter_pkg::MSG_ALL_WARN];
    assign redMsg[s] = m[lot_counter_pkg::MSG_OK_STOP] | m[lot_counter_pkg::MSG_ALL_STOP];
  end

  // ****************************************
  // Halt control
  // ****************************************
  // Job total stop halts; package switch makes it warn only
  assign halt[lot_counter_pkg::SET_JOB] =
    msgs[lot_counter_pkg::SET_JOB*lot_counter_pkg::MSG_W + lot_counter_pkg::MSG_OK_STOP]
    | (lot_counter_pkg::JOB_ALL_STOP_HALTS
       & msgs[lot_counter_pkg::SET_JOB*lot_counter_pkg::MSG_W + lot_counter_pkg::MSG_ALL_STOP]);
  assign halt[lot_counter_pkg::SET_SHIFT] = redMsg[lot_counter_pkg::SET_SHIFT];

  assign errorOut = msgs[lot_counter_pkg::SET_JOB*lot_counter_pkg::MSG_W + lot_counter_pkg::MSG_OK_STOP];

  // Halt while any stop latched; set reset clears it
  always_comb begin
    case (state_reg)
      lot_counter_pkg::RUN: state_next = (|halt) ? lot_counter_pkg::HALTED : lot_counter_pkg::RUN;
      lot_counter_pkg::HALTED: state_next = (|halt) ? lot_counter_pkg::HALTED : lot_counter_pkg::RUN;
      default: state_next = lot_counter_pkg::RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= lot_counter_pkg::RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ready = (state_reg == lot_counter_pkg::RUN);
endmodule // lot_size_part_counters

// file: shared/lot_counter_pkg.sv
// Constants and types shared by the lot size part counter files
package lot_counter_pkg;
  localparam int COUNT_W = 24;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
  localparam logic [COUNT_W-1:0] LIMIT_OFF = 24'h000000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;
  localparam int SET_JOB = 0;
  localparam int SET_SHIFT = 1;
  localparam int NUM_SETS = 2;
  // Bit positions inside a per-set message vector
  localparam int MSG_OK_WARN = 0;
  localparam int MSG_ALL_WARN = 1;
  localparam int MSG_OK_STOP = 2;
  localparam int MSG_ALL_STOP = 3;
  localparam int MSG_W = 4;
  // Job total stop: 1 ends the process, 0 only warns
  localparam logic JOB_ALL_STOP_HALTS = 1'b1;
  typedef enum logic [0:0] {RUN, HALTED} run_state_t;
endpackage

// file: verif/lot_counter_sva.sv
// Checker for counting, latching and halt relations
`timescale 1ns/1ps
module lot_counter_sva #(
  parameter int WIDTH = 24
) (
  input wire logic clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic measDone, // Stroke done
  input wire logic [1:0] clearSet, // Set reset
  input wire logic [1:0] acceptSet, // Apply
  input wire logic [1:0] showOkIn, // Pending flag
  input wire logic [2*WIDTH-1:0] okCount, // OK counts
  input wire logic [2*WIDTH-1:0] allCount, // Totals
  input wire logic [1:0] showOk, // Flags
  input wire logic [1:0] yellowMsg, // Warnings
  input wire logic [1:0] redMsg, // Stops
  input wire logic errorOut, // Job error
  input wire logic ready // Running
);
  localparam int W = WIDTH;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  total_step_a: assert property (measDone && ready && !clearSet[0] |=>
    allCount[W-1:0] == $past(allCount[W-1:0]) + 1'h1) else $error("Job total missed a step");
  set_clear_a: assert property (clearSet[0] |=> okCount[W-1:0] == 24'h0 &&
    allCount[W-1:0] == 24'h0 && !yellowMsg[0] && !redMsg[0] && !errorOut) else $error("Job set not cleared");
  halt_hold_a: assert property (!ready && clearSet == 2'h0 |=> $stable(allCount))
    else $error("Counted while halted");
  job_halt_a: assert property ($rose(redMsg[0]) |=> !ready) else $error("Job stop kept ready");
  shift_halt_a: assert property ($rose(redMsg[1]) |=> !ready) else $error("Shift stop kept ready");
  warn_keep_a: assert property (yellowMsg[0] && !clearSet[0] |=> yellowMsg[0])
    else $error("Warning not latched");
  flag_load_a: assert property (acceptSet[0] |=> showOk[0] == $past(showOkIn[0]))
    else $error("Flag not applied");
  error_red_a: assert property (errorOut |-> redMsg[0]) else $error("Error without stop message");
endmodule // lot_counter_sva

// file: verif/lot_size_part_counters_bench.sv
// Bench for the job and shift lot counters
`timescale 1ns/1ps
module lot_size_part_counters_bench;
  localparam int W = lot_counter_pkg::COUNT_W;
  logic clk, rst, measDone, measOk, req, reqOk, restart, errorOut, ready;
  logic [1:0] clearSet, acceptSet, showOkIn, showAllIn, showOk, showAll, yellowMsg, redMsg;
  logic [2*W-1:0] ok_warn_limit, all_parts_warn_limit, ok_stop_limit, all_parts_stop_limit, okCount, allCount;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  lot_size_part_counters #(.WIDTH(W)) u_lot_size_part_counters (.clk, .sys_rst(rst), .measDone, .measOk,
    .clearSet, .acceptSet, .ok_warn_limit, .all_parts_warn_limit, .ok_stop_limit, .all_parts_stop_limit,
    .showOkIn, .showAllIn, .okCount, .allCount, .showOk, .showAll, .yellowMsg, .redMsg, .errorOut, .ready);
  press_controller_model u_press_controller_model (.clk, .ready, .req, .reqOk, .restart, .measDone, .measOk);
  task print_verdict();
    $display("Errors %0d, checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [W-1:0] got, input logic [W-1:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Result is settled two edges after the stroke is taken
  task meas(input logic ok);
    @(posedge clk);
    req <= 1'h1;
    reqOk <= ok;
    @(posedge clk);
    req <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task cfg(input int s, input logic [W-1:0] ow, aw, os, as2);
    @(posedge clk);
    ok_warn_limit[s*W +: W] <= ow;
    all_parts_warn_limit[s*W +: W] <= aw;
    ok_stop_limit[s*W +: W] <= os;
    all_parts_stop_limit[s*W +: W] <= as2;
    acceptSet[s] <= 1'h1;
    @(posedge clk);
    acceptSet[s] <= 1'h0;
    #1;
  endtask
  // Set reset first, restart after ready is back
  task clr(input int s);
    @(posedge clk);
    clearSet[s] <= 1'h1;
    @(posedge clk);
    clearSet[s] <= 1'h0;
    repeat (2) @(posedge clk);
    restart <= 1'h1;
    @(posedge clk);
    restart <= 1'h0;
    #1;
  endtask
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    rst = 1'h1;
    restart = 1'h1;
    {req, reqOk, clearSet, acceptSet, showOkIn, showAllIn} = '0;
    {ok_warn_limit, all_parts_warn_limit, ok_stop_limit, all_parts_stop_limit} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    restart <= 1'h0;
    showOkIn <= 2'h3;
    showAllIn <= 2'h2;
    repeat (2) @(posedge clk);
    #1;
    chk(showOk, 2'h0);
    cfg(0, 24'h2, 24'h0, 24'h3, 24'h0);
    chk({showAll, showOk}, 4'h1);
    meas(1'h1);
    meas(1'h0);
    chk(okCount[W-1:0], 24'h1);
    chk(allCount[W-1:0], 24'h2);
    meas(1'h1);
    chk({yellowMsg, redMsg, ready}, 5'h09);
    meas(1'h1);
    chk({yellowMsg, redMsg, errorOut, ready}, 6'h16);
    chk(okCount[W +: W], 24'h3);
    chk(allCount[W +: W], 24'h4);
    meas(1'h1);
    chk(allCount[W-1:0], 24'h4);
    clr(0);
    chk(okCount[W-1:0] | allCount[W-1:0], 24'h0);
    chk({yellowMsg, redMsg, errorOut, ready}, 6'h01);
    chk(allCount[W +: W], 24'h4);
    meas(1'h1);
    chk(okCount[W-1:0], 24'h1);
    cfg(1, 24'h0, 24'h6, 24'h0, 24'h7);
    meas(1'h0);
    chk(yellowMsg, 2'h2);
    meas(1'h0);
    chk({redMsg, errorOut, ready}, 4'h8);
    clr(1);
    chk({redMsg, ready}, 3'h1);
    cfg(0, 24'h0, 24'h0, 24'h0, 24'h4);
    meas(1'h0);
    chk({redMsg, errorOut, ready}, 4'h4);
    clr(0);
    print_verdict();
  end
endmodule // lot_size_part_counters_bench
bind lot_size_part_counters lot_counter_sva #(.WIDTH(WIDTH)) u_lot_counter_sva (.clk, .sys_rst, .measDone,
  .clearSet, .acceptSet, .showOkIn, .okCount, .allCount, .showOk, .yellowMsg, .redMsg, .errorOut, .ready);

// file: verif/press_controller_model.sv
// Machine controller model that presses on request until the monitor drops ready, then waits for a restart
`timescale 1ns/1ps
module press_controller_model (
  input wire logic clk, // Clock
  input wire logic ready, // Monitor ready
  input wire logic req, // Press request
  input wire logic reqOk, // Wanted result
  input wire logic restart, // Operator restart
  output logic measDone, // Stroke done
  output logic measOk // Stroke result
);
  logic running;
  always_ff @(posedge clk) begin
    if (restart) running <= 1'h1;
    else if (!ready) running <= 1'h0;
  end
  // Result line carries no meaning outside a stroke
  always_ff @(posedge clk) begin
    measDone <= req && running;
    measOk <= req ? reqOk : !reqOk;
  end
endmodule // press_controller_model
